// File: common/fwsr_pkg.sv
package fwsr_pkg;

    // Register offsets of the controller's own APB register file.
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_ADDR   = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_LAST   = 8'h0C;
    localparam logic [7:0] OFS_POLLS  = 8'h10;

    // Control register field positions.
    localparam int CTRL_START = 0;
    localparam int CTRL_ABORT = 1;
    localparam int CTRL_WSEL  = 2;

    // Status register field positions.
    localparam int ST_BUSY    = 0;
    localparam int ST_DONE    = 1;
    localparam int ST_FAIL    = 2;
    localparam int ST_WINDOW  = 3;
    localparam int ST_SUSP    = 4;

    // Status bit positions inside the flash data byte.
    localparam int BIT_POLL   = 7;
    localparam int BIT_TOG_A  = 6;
    localparam int BIT_FAIL   = 5;
    localparam int BIT_WINDOW = 3;
    localparam int BIT_TOG_B  = 2;

    // Reset command byte written after a time-limit failure.
    localparam logic [7:0] CMD_RESET = 8'hF0;

    // Flash bus strobe timing in controller clocks.
    localparam int CLK_NS       = 10;
    localparam int STROBE_NS    = 90;
    localparam int STROBE_CYC   = (STROBE_NS + CLK_NS - 1) / CLK_NS;
    localparam int RECOVER_NS   = 20;
    localparam int RECOVER_CYC  = (RECOVER_NS + CLK_NS - 1) / CLK_NS;

    // Host-side spacing bound for extra sector erase commands.
    localparam int ERASE_GAP_US = 50;

    localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

endpackage

// File: core/fwsr_bus_cycle.sv
`timescale 1ns/1ps
// One asynchronous flash bus cycle: strobe low for a fixed time, then
// a recovery gap with all strobes high before the next cycle.
module fwsr_bus_cycle #(
    parameter int AW = 19
) (
    input  wire logic          ref_clk,
    input  wire logic          reset_n,
    input  wire logic          clk_en,
    input  wire logic          req,
    input  wire logic          wr,
    input  wire logic [AW-1:0] addr,
    input  wire logic [7:0]    wdata,
    input  wire logic [7:0]    fl_dq_in,
    output logic               busy,
    output logic               done,
    output logic [7:0]         rdata,
    output logic [AW-1:0]      fl_addr,
    output logic [7:0]         fl_dq_out,
    output logic               fl_dq_oe,
    output logic               fl_ce_n,
    output logic               fl_oe_n,
    output logic               fl_we_n
);
    localparam logic [7:0] STB = 8'(fwsr_pkg::STROBE_CYC);
    localparam logic [7:0] REC = 8'(fwsr_pkg::RECOVER_CYC);

    typedef enum logic [1:0] {BC_IDLE, BC_STROBE, BC_REC} fwsr_bc_type;
    fwsr_bc_type st_q;
    logic [7:0]  cnt_q;
    logic        wr_q;

    wire strobe_end = (st_q == BC_STROBE) && (cnt_q == 8'h01);
    wire rec_end    = (st_q == BC_REC) && (cnt_q == 8'h01);

    // Cycle sequencer; read data is captured just before strobe release.
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            st_q <= BC_IDLE; cnt_q <= 8'h00; wr_q <= 1'b0; busy <= 1'b0;
            done <= 1'b0; rdata <= 8'h00; fl_addr <= '0; fl_dq_out <= 8'h00;
            fl_dq_oe <= 1'b0; fl_ce_n <= 1'b1; fl_oe_n <= 1'b1;
            fl_we_n <= 1'b1;
        end
        else if (clk_en)
        begin
            done <= 1'b0;
            case (st_q)
                BC_IDLE:
                    if (req)
                    begin
                        st_q <= BC_STROBE; cnt_q <= STB; wr_q <= wr;
                        busy <= 1'b1; fl_addr <= addr; fl_dq_out <= wdata;
                        fl_dq_oe <= wr; fl_ce_n <= 1'b0;
                        fl_oe_n <= wr; fl_we_n <= !wr;
                    end
                BC_STROBE:
                    if (strobe_end)
                    begin
                        // Write data latches on the rising write strobe.
                        st_q <= BC_REC; cnt_q <= REC; fl_ce_n <= 1'b1;
                        fl_oe_n <= 1'b1; fl_we_n <= 1'b1;
                        if (!wr_q)
                            rdata <= fl_dq_in;
                    end
                    else
                        cnt_q <= cnt_q - 8'h01;
                BC_REC:
                    if (rec_end)
                    begin
                        st_q <= BC_IDLE; busy <= 1'b0; done <= 1'b1;
                        fl_dq_oe <= 1'b0;
                    end
                    else
                        cnt_q <= cnt_q - 8'h01;
                default: st_q <= BC_IDLE;
            endcase
        end
    end
endmodule

// File: core/fwsr_apb_regs.sv
`timescale 1ns/1ps
// APB slave for the controller's own registers; answers with no wait.
module fwsr_apb_regs #(
    parameter int AW = 19
) (
    input  wire logic          ref_clk,
    input  wire logic          reset_n,
    input  wire logic          clk_en,
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [7:0]    paddr,
    input  wire logic [31:0]   pwdata,
    output logic [31:0]        prdata,
    output logic               pready,
    output logic               pslverr,
    input  wire logic [4:0]    status,
    input  wire logic [7:0]    last_byte,
    input  wire logic [15:0]   poll_count,
    output logic               start_pulse,
    output logic               abort_pulse,
    output logic               watch_b,
    output logic [AW-1:0]      target_addr
);
    wire acc = psel && !penable;
    // Writes land only at the edge that completes the access phase.
    wire wr  = psel && penable && pready && pwrite;
    wire hit_ctrl = (paddr == fwsr_pkg::OFS_CTRL);
    wire hit_addr = (paddr == fwsr_pkg::OFS_ADDR);
    wire hit_st   = (paddr == fwsr_pkg::OFS_STATUS);
    wire hit_last = (paddr == fwsr_pkg::OFS_LAST);
    wire hit_poll = (paddr == fwsr_pkg::OFS_POLLS);
    wire mapped   = hit_ctrl | hit_addr | hit_st | hit_last | hit_poll;
    wire [31:0] rd_mux =
        hit_ctrl ? {29'h0, watch_b, 2'b00} :
        hit_addr ? {{(32-AW){1'b0}}, target_addr} :
        hit_st   ? {27'h0, status} :
        hit_last ? {24'h0, last_byte} :
        hit_poll ? {16'h0, poll_count} : fwsr_pkg::ZERO_WORD;

    // Answer in the cycle after setup; unmapped offsets raise pslverr.
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            prdata <= 32'h0;
            pready <= 1'b0;
            pslverr <= 1'b0;
            start_pulse <= 1'b0;
            abort_pulse <= 1'b0;
            watch_b <= 1'b0;
            target_addr <= '0;
        end
        else if (clk_en)
        begin
            pready <= acc;
            pslverr <= acc && !mapped;
            prdata <= (acc && !pwrite) ? rd_mux : 32'h0;
            start_pulse <= wr && hit_ctrl && pwdata[fwsr_pkg::CTRL_START];
            abort_pulse <= wr && hit_ctrl && pwdata[fwsr_pkg::CTRL_ABORT];
            if (wr && hit_ctrl)
                watch_b <= pwdata[fwsr_pkg::CTRL_WSEL];
            if (wr && hit_addr)
                target_addr <= pwdata[AW-1:0];
        end
    end
endmodule

// File: core/fwsr_poll_ctrl.sv
`timescale 1ns/1ps
// Contract
// - Host reads status at program address or erasing sector address.
// - Host reads status twice, compares toggle bit; unchanged means done.
// - Still toggling: test bit 5, then recheck toggle for pass or fail.
// - Resumed polling restarts from the first double read; code re-enters PC_READ2 for one new read instead.
// - After a bit 5 failure host writes the reset command.
// - Host may skip bit 3 only with commands under 50 us apart.
// - Host checks bit 3 before and after each extra erase command.
//
// Toggle-bit polling engine. Software names the poll address (the program
// address or an address in an erasing sector) and starts; the engine
// runs the double-read algorithm, recovers with the reset command on a
// time-limit failure and reports the outcome through APB registers.
module fwsr_poll_ctrl #(
    parameter int AW = 19
) (
    input  wire logic          ref_clk,
    input  wire logic          reset_n,
    input  wire logic          clk_en,
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [7:0]    paddr,
    input  wire logic [31:0]   pwdata,
    output logic [31:0]        prdata,
    output logic               pready,
    output logic               pslverr,
    output logic [AW-1:0]      fl_addr,
    input  wire logic [7:0]    fl_dq_in,
    output logic [7:0]         fl_dq_out,
    output logic               fl_dq_oe,
    output logic               fl_ce_n,
    output logic               fl_oe_n,
    output logic               fl_we_n
);
    typedef enum logic [2:0]
    {
        PC_IDLE, PC_READ1, PC_READ2, PC_RECHECK, PC_RESET
    } fwsr_pc_type;

    fwsr_pc_type st_q;
    fwsr_pc_type st_d;
    logic [7:0]  prev_q;
    logic [7:0]  last_q;
    logic [15:0] polls_q;
    logic        done_q;
    logic        fail_q;
    logic        window_q;
    logic        susp_q;
    logic        issued_q;

    logic          start_pulse;
    logic          abort_pulse;
    logic          watch_b;
    logic [AW-1:0] target_addr;
    logic          cyc_busy;
    logic          cyc_done;
    logic [7:0]    cyc_rdata;

    wire [4:0] status = {susp_q, window_q, fail_q, done_q,
                         (st_q != PC_IDLE)};

    fwsr_apb_regs #(.AW(AW)) u_regs (
        .ref_clk     (ref_clk),
        .reset_n     (reset_n),
        .clk_en      (clk_en),
        .psel        (psel),
        .penable     (penable),
        .pwrite      (pwrite),
        .paddr       (paddr),
        .pwdata      (pwdata),
        .prdata      (prdata),
        .pready      (pready),
        .pslverr     (pslverr),
        .status      (status),
        .last_byte   (last_q),
        .poll_count  (polls_q),
        .start_pulse (start_pulse),
        .abort_pulse (abort_pulse),
        .watch_b     (watch_b),
        .target_addr (target_addr)
    );

    // Only read cycles are issued while polling, so the device's command
    // state is never disturbed except by the deliberate reset write.
    wire issue_rd  = (st_q == PC_READ1) || (st_q == PC_READ2) ||
                     (st_q == PC_RECHECK);
    wire issue_wr  = (st_q == PC_RESET);
    wire cyc_req   = (issue_rd || issue_wr) && !issued_q && !cyc_busy;

    fwsr_bus_cycle #(.AW(AW)) u_cycle (
        .ref_clk   (ref_clk),
        .reset_n   (reset_n),
        .clk_en    (clk_en),
        .req       (cyc_req),
        .wr        (issue_wr),
        .addr      (target_addr),
        .wdata     (fwsr_pkg::CMD_RESET),
        .fl_dq_in  (fl_dq_in),
        .busy      (cyc_busy),
        .done      (cyc_done),
        .rdata     (cyc_rdata),
        .fl_addr   (fl_addr),
        .fl_dq_out (fl_dq_out),
        .fl_dq_oe  (fl_dq_oe),
        .fl_ce_n   (fl_ce_n),
        .fl_oe_n   (fl_oe_n),
        .fl_we_n   (fl_we_n)
    );

    // Toggle comparison on the chosen toggle bit between two reads.
    wire tog_a   = cyc_rdata[fwsr_pkg::BIT_TOG_A] ^
                   prev_q[fwsr_pkg::BIT_TOG_A];
    wire tog_b   = cyc_rdata[fwsr_pkg::BIT_TOG_B] ^
                   prev_q[fwsr_pkg::BIT_TOG_B];
    wire toggled = watch_b ? tog_b : tog_a;
    wire fail_hi = cyc_rdata[fwsr_pkg::BIT_FAIL];
    // Bit 6 still while bit 2 toggles marks a suspended erase sector.
    wire suspended = !tog_a && tog_b;

    // Next-state decode of the polling algorithm.
    always_comb
    begin
        st_d = st_q;
        case (st_q)
            PC_IDLE:
                if (start_pulse)
                    st_d = PC_READ1;
            PC_READ1:
                if (cyc_done)
                    st_d = PC_READ2;
            PC_READ2:
                if (cyc_done)
                begin
                    if (!toggled)
                        st_d = PC_IDLE;
                    else if (fail_hi)
                        st_d = PC_RECHECK;
                    else
                        st_d = PC_READ2;
                end
            PC_RECHECK:
                if (cyc_done)
                    st_d = toggled ? PC_RESET : PC_IDLE;
            PC_RESET:
                if (cyc_done)
                    st_d = PC_IDLE;
            default: st_d = PC_IDLE;
        endcase
        // Abort drops the sequence only while no bus cycle is busy; a later start begins afresh.
        if (abort_pulse && !cyc_busy)
            st_d = PC_IDLE;
    end

    // Sequencer state and captured bytes.
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            st_q <= PC_IDLE;
            issued_q <= 1'b0;
            prev_q <= 8'h00;
            last_q <= 8'h00;
            polls_q <= 16'h0000;
        end
        else if (clk_en)
        begin
            st_q <= st_d;
            if (cyc_req)
                issued_q <= 1'b1;
            else if (cyc_done)
                issued_q <= 1'b0;
            if (start_pulse && st_q == PC_IDLE)
                polls_q <= 16'h0000;
            if (cyc_done && issue_rd)
            begin
                prev_q <= cyc_rdata;
                last_q <= cyc_rdata;
                polls_q <= polls_q + 16'h0001;
            end
        end
    end

    // Outcome flags: done, failure, erase window and suspension seen.
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            done_q <= 1'b0;
            fail_q <= 1'b0;
            window_q <= 1'b0;
            susp_q <= 1'b0;
        end
        else if (clk_en)
        begin
            if (start_pulse && st_q == PC_IDLE)
            begin
                done_q <= 1'b0;
                fail_q <= 1'b0;
                susp_q <= 1'b0;
            end
            else if (cyc_done && st_q == PC_READ2)
            begin
                done_q <= !toggled;
                window_q <= cyc_rdata[fwsr_pkg::BIT_WINDOW];
                susp_q <= suspended;
            end
            else if (cyc_done && st_q == PC_RECHECK)
            begin
                done_q <= 1'b1;
                fail_q <= toggled;
                // Bit 5 reads 0 while suspended, so a recheck never ends
                // in a suspension; any earlier mark is a hand-over artefact.
                susp_q <= 1'b0;
            end
        end
    end
endmodule

// File: tb/fwsr_poll_chk.sv
`timescale 1ns/1ps
// Pin-level watcher for the polling controller.
module fwsr_poll_chk #(
    parameter int AW = 19
) (
    input wire logic          ref_clk,
    input wire logic          reset_n,
    input wire logic          clk_en,
    input wire logic          psel,
    input wire logic          penable,
    input wire logic          pwrite,
    input wire logic [7:0]    paddr,
    input wire logic [31:0]   pwdata,
    input wire logic [31:0]   prdata,
    input wire logic          pready,
    input wire logic          pslverr,
    input wire logic [AW-1:0] fl_addr,
    input wire logic [7:0]    fl_dq_in,
    input wire logic [7:0]    fl_dq_out,
    input wire logic          fl_dq_oe,
    input wire logic          fl_ce_n,
    input wire logic          fl_oe_n,
    input wire logic          fl_we_n
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    // A setup that goes unanswered would hang software forever.
    a_apb_answer: assert property (psel && !penable && clk_en |=> pready)
        else $error("setup not answered next cycle");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready held longer than one cycle");
    a_err_unmapped: assert property (psel && !penable && clk_en
        && (paddr > 8'h10 || paddr[1:0] != 2'b00) |=> pslverr && pready)
        else $error("unmapped offset not refused");
    a_err_mapped: assert property (psel && !penable && clk_en
        && paddr <= 8'h10 && paddr[1:0] == 2'b00 |=> !pslverr)
        else $error("mapped offset refused");
    // Short strobes would sample the status byte before it is valid.
    a_read_width: assert property (
        $fell(fl_oe_n) |-> ##1 (!fl_oe_n)[*8] ##1 fl_oe_n)
        else $error("read strobe not nine cycles");
    a_recover_gap: assert property (
        $rose(fl_ce_n) |-> (fl_ce_n && fl_oe_n && fl_we_n)[*2])
        else $error("recovery gap too short");
    a_read_excl: assert property (
        !fl_oe_n |-> fl_we_n && !fl_ce_n && !fl_dq_oe)
        else $error("read overlaps a write or drive");
    a_addr_hold: assert property (
        !fl_ce_n && !$past(fl_ce_n) |-> $stable(fl_addr))
        else $error("flash address moved inside a cycle");
    a_reset_cmd: assert property (
        !fl_we_n |-> fl_dq_oe && fl_dq_out == fwsr_pkg::CMD_RESET)
        else $error("write cycle without reset command");
endmodule

bind fwsr_poll_ctrl fwsr_poll_chk #(.AW(AW)) fwsr_poll_chk_i (
    .ref_clk(ref_clk), .reset_n(reset_n), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .fl_addr(fl_addr), .fl_dq_in(fl_dq_in), .fl_dq_out(fl_dq_out),
    .fl_dq_oe(fl_dq_oe), .fl_ce_n(fl_ce_n), .fl_oe_n(fl_oe_n),
    .fl_we_n(fl_we_n));

// File: tb/fwsr_flash_model.sv
`timescale 1ns/1ps
// Flash device from its pins: status bytes while an algorithm runs.
module fwsr_flash_model #(
    parameter logic [2:0] SECTOR = 3'h5
) (
    input wire logic        ref_clk,
    input wire logic        load,
    input wire logic [7:0]  run_reads,
    input wire logic        fail_mode,
    input wire logic        susp_mode,
    input wire logic [7:0]  array_byte,
    input wire logic [18:0] fl_addr,
    input wire logic        fl_ce_n,
    input wire logic        fl_oe_n,
    input wire logic        fl_we_n,
    input wire logic [7:0]  fl_dq_out,
    input wire logic        fl_dq_oe,
    output logic [7:0]      fl_dq_in,
    output logic [7:0]      reset_cnt,
    output logic [18:0]     rd_addr
);
    logic [7:0] left_q;
    logic [7:0] cmd_q;
    logic [7:0] last_q;
    logic [7:0] byte_w;
    logic       tog_a_q = 1'b0;
    logic       tog_b_q = 1'b0;
    logic       fail_q;
    logic       susp_q;
    logic       rd_q;
    logic       wr_q;
    wire        rd_on = !fl_ce_n && !fl_oe_n;
    wire        wr_on = !fl_ce_n && !fl_we_n;
    wire        in_sec = fl_addr[18:16] == SECTOR;
    wire        busy_w = left_q != 8'h00 || fail_q;

    // Status while busy or while suspended in the sector, stored data otherwise.
    assign byte_w = busy_w
        ? {1'b0, tog_a_q, fail_q, 2'b01, in_sec & tog_b_q, 2'h0}
        : (susp_q && in_sec) ? {1'b1, tog_a_q, 3'h0, tog_b_q, 2'h0}
        : array_byte;
    // A released bus shows the inverse of the last byte, never a copy.
    assign fl_dq_in = rd_on ? byte_w : ~last_q;

    // Bits flip once per finished read; the reset command ends a run.
    always @(posedge ref_clk)
    begin
        rd_q <= rd_on;
        wr_q <= wr_on;
        if (rd_on)
        begin
            last_q <= byte_w;
            rd_addr <= fl_addr;
        end
        if (wr_on && fl_dq_oe)
            cmd_q <= fl_dq_out;
        if (load)
        begin
            left_q <= run_reads;
            fail_q <= fail_mode;
            susp_q <= susp_mode;
            reset_cnt <= 8'h00;
        end
        else if (wr_q && !wr_on && cmd_q == 8'hF0)
        begin
            left_q <= 8'h00;
            fail_q <= 1'b0;
            reset_cnt <= reset_cnt + 8'h01;
        end
        else if (rd_q && !rd_on)
        begin
            if (busy_w)
                tog_a_q <= ~tog_a_q;
            if (rd_addr[18:16] == SECTOR && (busy_w || susp_q))
                tog_b_q <= ~tog_b_q;
            if (left_q != 8'h00)
                left_q <= left_q - 8'h01;
        end
    end
endmodule

// File: tb/testbench.sv
`timescale 1ns/1ps
// Self-checking bench for the toggle-bit polling controller.
module testbench;
    typedef struct {logic [32:0] v; logic [32:0] m;} fwsr_note_type;
    logic          ref_clk = 1'b0;
    logic          reset_n = 1'b0;
    logic          psel = 1'b0;
    logic          penable = 1'b0;
    logic          pwrite = 1'b0;
    logic          load = 1'b1;
    logic          clk_en = 1'b1;
    logic          fail_m = 1'b0;
    logic          susp_m = 1'b0;
    logic [7:0]    paddr = 8'h00;
    logic [7:0]    run_n = 8'h00;
    logic [7:0]    arr = 8'h00;
    logic [31:0]   pwdata = 32'h0000_0000;
    logic [15:0]   seed = 16'h0015;
    logic [31:0]   prdata;
    logic          pready;
    logic          pslverr;
    logic          fl_ce_n;
    logic          fl_oe_n;
    logic          fl_we_n;
    logic          fl_dq_oe;
    logic [18:0]   fl_addr;
    logic [18:0]   rd_addr;
    logic [7:0]    fl_dq_in;
    logic [7:0]    fl_dq_out;
    logic [7:0]    reset_cnt;
    logic [31:0]   r;
    fwsr_note_type note;
    fwsr_note_type notes[$];
    int            error_cnt = 0;
    int            checks = 0;

    fwsr_poll_ctrl #(.AW(19)) fwsr_poll_ctrl_i (
        .ref_clk(ref_clk), .reset_n(reset_n), .clk_en(clk_en), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .fl_addr(fl_addr), .fl_dq_in(fl_dq_in),
        .fl_dq_out(fl_dq_out), .fl_dq_oe(fl_dq_oe), .fl_ce_n(fl_ce_n),
        .fl_oe_n(fl_oe_n), .fl_we_n(fl_we_n));
    fwsr_flash_model fwsr_flash_model_i (
        .ref_clk(ref_clk), .load(load), .run_reads(run_n),
        .fail_mode(fail_m), .susp_mode(susp_m), .array_byte(arr),
        .fl_addr(fl_addr), .fl_ce_n(fl_ce_n), .fl_oe_n(fl_oe_n),
        .fl_we_n(fl_we_n), .fl_dq_out(fl_dq_out), .fl_dq_oe(fl_dq_oe),
        .fl_dq_in(fl_dq_in), .reset_cnt(reset_cnt), .rd_addr(rd_addr));

    // Clock of 10 ns period.
    always #5 ref_clk = ~ref_clk;

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
        checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("wrong value at %0t: seen %h expected %h",
                $time, seen, exp);
        end
    endtask

    task automatic results();
        if (error_cnt == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // One APB transfer; the request stands until pready is sampled.
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        @(posedge ref_clk);
        while (pready !== 1'b1 && n < 50)
        begin
            @(posedge ref_clk);
            n++;
        end
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50)
        begin
            error_cnt++;
            results();
        end
        @(posedge ref_clk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [32:0] m,
                      input logic [32:0] v, output logic [31:0] q);
        notes.push_back('{v: v & m, m: m});
        apb(1'b0, a, 32'h0000_0000, q);
    endtask

    // One polling job against a device run of the given shape.
    task automatic run(input logic [7:0] n, input logic ws, su, fa, ins,
                       input logic [32:0] m, input logic [32:0] v);
        logic [18:0] pa;
        int k;
        seed = lfsr(seed);
        pa = {ins ? 3'h5 : 3'h2, seed};
        arr <= seed[15:8];
        run_n <= n;
        fail_m <= fa;
        susp_m <= su;
        load <= 1'b1;
        apb(1'b1, fwsr_pkg::OFS_ADDR, {13'h0000, pa}, r);
        load <= 1'b0;
        apb(1'b1, fwsr_pkg::OFS_CTRL, {29'h0000_0000, ws, 2'b01}, r);
        // A frozen clock enable must only delay the first flash cycle.
        if (fa)
        begin
            clk_en <= 1'b0;
            repeat (4) @(posedge ref_clk);
            clk_en <= 1'b1;
        end
        k = 0;
        while (fl_ce_n !== 1'b0 && k < 50)
        begin
            @(posedge ref_clk);
            k++;
        end
        r = 32'hFFFF_FFFF;
        while (r[0] !== 1'b0 && k < 400)
        begin
            rd(fwsr_pkg::OFS_STATUS, {1'b1, 32'h0}, 33'h0, r);
            k++;
        end
        if (k >= 400)
        begin
            error_cnt++;
            results();
        end
        rd(fwsr_pkg::OFS_STATUS, m, v, r);
        chk({14'h0000, rd_addr}, {14'h0000, pa});
        if (!fa && !(su && ins))
            rd(fwsr_pkg::OFS_LAST, 33'hFF, {25'h0, arr}, r);
    endtask

    // Each read answer is matched against the oldest note.
    always @(posedge ref_clk)
    begin
        if (psel && penable && pready === 1'b1 && !pwrite)
        begin
            note = notes.pop_front();
            chk({pslverr, prdata} & note.m, note.v);
        end
    end

    initial
    begin
        repeat (8) @(posedge ref_clk);
        reset_n <= 1'b1;
        load <= 1'b0;
        @(posedge ref_clk);
        rd(fwsr_pkg::OFS_STATUS, {33{1'b1}}, 33'h0, r);
        rd(8'h14, {33{1'b1}}, {1'b1, 32'h0000_0000}, r);
        seed = lfsr(seed);
        apb(1'b1, fwsr_pkg::OFS_ADDR, {13'h0000, 3'h2, seed}, r);
        rd(fwsr_pkg::OFS_ADDR, {33{1'b1}}, {14'h0, 3'h2, seed}, r);
        for (int i = 0; i < 4; i++)
            run(8'(i * 3), i[0], 1'b0, 1'b0, 1'b1, 33'h17, 33'h02);
        run(8'h02, 1'b0, 1'b0, 1'b1, 1'b1, 33'h05, 33'h04);
        chk({25'h0, reset_cnt}, 33'h1);
        run(8'h00, 1'b0, 1'b1, 1'b0, 1'b1, 33'h1F, 33'h12);
        run(8'h00, 1'b1, 1'b1, 1'b0, 1'b0, 33'h17, 33'h02);
        results();
    end
endmodule
